// File: hdl/dmp_params.svh
// Timing counts, field positions and reset values of the memory pin link
`ifndef DMP_PARAMS_SVH
`define DMP_PARAMS_SVH
`define DMP_CLK_NS 25
`define DMP_LINK_NS 200
`define DMP_HALF_CYC ((`DMP_LINK_NS / `DMP_CLK_NS) / 2)
`define DMP_QTR_CYC (`DMP_HALF_CYC / 2)
`define DMP_DQ_W 36
`define DMP_ADDR_W 22
`define DMP_BANK_W 3
`define DMP_GRP_W 18
`define DMP_X18_SPLIT 9
`define DMP_COL_W 2
`define DMP_CFG_WIDTH_LSB 0
`define DMP_CFG_WIDTH_RST 2'h2
`define DMP_LANES_X9 36'h0000001FF
`define DMP_LANES_X18 36'h00003FFFF
`define DMP_LANES_X36 36'hFFFFFFFFF
`define DMP_FIFO_DEPTH 16
`endif

// File: hdl/dmp_pkg.sv
// Types shared by both ends of the memory pin link
`default_nettype none
package dmp_pkg;
    // Command code is {write_en_n, refresh_n}
    typedef enum logic [1:0] {DMP_CMD_CFG = 2'h0, DMP_CMD_WRITE = 2'h1,
        DMP_CMD_REFRESH = 2'h2, DMP_CMD_READ = 2'h3} dmp_cmd_t;
    typedef enum logic [1:0] {DMP_X9 = 2'h0, DMP_X18 = 2'h1, DMP_X36 = 2'h2} dmp_width_t;
    typedef enum logic [2:0] {RD_IDLE = 3'h1, RD_BEAT0 = 3'h2, RD_BEAT1 = 3'h4} dmp_rd_st_t;
    typedef enum logic [4:0] {C_IDLE = 5'h01, C_CMD = 5'h02, C_WB0 = 5'h04, C_WB1 = 5'h08,
        C_RWAIT = 5'h10} dmp_ctl_st_t;
endpackage : dmp_pkg
`default_nettype wire

// File: hdl/dmp_link_if.sv
// Pin bundle between the memory controller end and the memory device end
`include "dmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
interface dmp_link_if;
    logic clock;
    logic clock_n;
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [`DMP_ADDR_W-1:0] addr_in;
    logic [`DMP_BANK_W-1:0] bank_sel;
    logic wr_strobe_lo;
    logic wr_strobe_lo_n;
    logic wr_strobe_hi;
    logic wr_strobe_hi_n;
    logic write_mask;
    logic [`DMP_DQ_W-1:0] ctl_dq_o;
    logic [`DMP_DQ_W-1:0] ctl_dq_oe_n;
    logic [`DMP_DQ_W-1:0] dev_dq_o;
    logic [`DMP_DQ_W-1:0] dev_dq_oe_n;
    logic [`DMP_DQ_W-1:0] data_bus;
    logic rd_strobe_lo;
    logic rd_strobe_lo_n;
    logic rd_strobe_hi;
    logic rd_strobe_hi_n;
    logic read_valid;
    // Resolve the shared data wire; controller wins, released lanes read low
    assign data_bus = (~ctl_dq_oe_n & ctl_dq_o) | (ctl_dq_oe_n & ~dev_dq_oe_n & dev_dq_o);
    modport ctl (output clock, clock_n, cs_n, we_n, ref_n, addr_in, bank_sel,
        wr_strobe_lo, wr_strobe_lo_n, wr_strobe_hi, wr_strobe_hi_n, write_mask,
        ctl_dq_o, ctl_dq_oe_n, input data_bus, rd_strobe_lo, rd_strobe_lo_n,
        rd_strobe_hi, rd_strobe_hi_n, read_valid);
    modport dev (input clock, clock_n, cs_n, we_n, ref_n, addr_in, bank_sel,
        wr_strobe_lo, wr_strobe_lo_n, wr_strobe_hi, wr_strobe_hi_n, write_mask,
        data_bus, output dev_dq_o, dev_dq_oe_n, rd_strobe_lo, rd_strobe_lo_n,
        rd_strobe_hi, rd_strobe_hi_n, read_valid);
endinterface : dmp_link_if
`default_nettype wire

// File: hdl/dmp_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dmp_fifo
#(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
)
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    wire logic push = in_valid_i && in_ready_o;
    wire logic pop = out_valid_o && out_ready_i;
    // Full when the pointers wrap apart, empty when equal
    assign in_ready_o = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
        (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
    assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];
    assign count_o = wr_ptr_ff - rd_ptr_ff;
    // Pointer update
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
        end
    end
    // Storage write
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
endmodule : dmp_fifo
`default_nettype wire

// File: hdl/dmp_ctl_end.sv
// Memory controller end: makes the link clocks, issues commands, collects reads
`include "dmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dmp_ctl_end
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    dmp_link_if.ctl link,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire dmp_pkg::dmp_cmd_t cmd_op_i,
    input wire logic [`DMP_BANK_W-1:0] cmd_bank_i,
    input wire logic [`DMP_ADDR_W-1:0] cmd_addr_i,
    input wire logic [2*`DMP_DQ_W-1:0] wr_data_i,
    input wire logic [1:0] wr_mask_i,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [`DMP_DQ_W-1:0] rd_data_o,
    output var dmp_pkg::dmp_width_t width_o
);
    import dmp_pkg::*;
    localparam int DW = `DMP_DQ_W;
    localparam int SW = DW + 3;
    // ==========================================
    // Link clock divider
    logic [2:0] ph_ff;
    logic clk_pin_ff;
    logic stb_pin_ff;
    wire logic at_fall = (ph_ff == 3'(`DMP_HALF_CYC - 1));
    wire logic at_rise = (ph_ff == 3'(2 * `DMP_HALF_CYC - 1));
    wire logic [2:0] nxt_ph = at_rise ? 3'h0 : ph_ff + 3'h1;
    // Clock high in the first half; write strobes lag a quarter period
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ph_ff <= 3'h0;
            clk_pin_ff <= 1'h0;
            stb_pin_ff <= 1'h0;
        end
        else
        begin
            ph_ff <= nxt_ph;
            clk_pin_ff <= (nxt_ph < 3'(`DMP_HALF_CYC));
            stb_pin_ff <= (nxt_ph >= 3'(`DMP_QTR_CYC)) &&
                (nxt_ph < 3'(`DMP_QTR_CYC + `DMP_HALF_CYC));
        end
    end
    // ==========================================
    // Command issue
    dmp_ctl_st_t st_ff;
    dmp_cmd_t op_ff;
    dmp_width_t width_ff;
    logic cs_n_ff;
    logic [`DMP_ADDR_W-1:0] addr_ff;
    logic [`DMP_BANK_W-1:0] bank_ff;
    logic [2*DW-1:0] wbuf_ff;
    logic [1:0] mbuf_ff;
    logic [DW-1:0] dq_ff;
    logic [DW-1:0] oe_n_ff;
    logic mask_ff;
    logic [1:0] rcnt_ff;
    logic push_ff;
    logic fifo_rdy;
    logic [4:0] fifo_cnt;
    wire logic room = fifo_rdy && (fifo_cnt <= 5'(`DMP_FIFO_DEPTH - 2));
    wire logic accept = cmd_ready_o && cmd_valid_i;
    wire logic [DW-1:0] lanes = (width_ff == DMP_X9) ? `DMP_LANES_X9 :
        ((width_ff == DMP_X18) ? `DMP_LANES_X18 : `DMP_LANES_X36);
    assign cmd_ready_o = (st_ff == C_IDLE) && at_fall && (cmd_op_i != DMP_CMD_READ || room);
    // Pins change on clock fall so they are stable at the rise
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cs_n_ff <= 1'h1;
            op_ff <= DMP_CMD_READ;
            addr_ff <= '0;
            bank_ff <= '0;
            wbuf_ff <= '0;
            mbuf_ff <= 2'h0;
            width_ff <= dmp_width_t'(`DMP_CFG_WIDTH_RST);
        end
        else if (at_fall)
        begin
            cs_n_ff <= !accept;
            if (accept)
            begin
                op_ff <= cmd_op_i;
                addr_ff <= cmd_addr_i;
                bank_ff <= cmd_bank_i;
                wbuf_ff <= wr_data_i;
                mbuf_ff <= wr_mask_i;
                if (cmd_op_i == DMP_CMD_CFG && cmd_addr_i[1:0] != 2'h3)
                    width_ff <= dmp_width_t'(cmd_addr_i[`DMP_CFG_WIDTH_LSB +: 2]);
            end
        end
    end
    // Write beats: first with the clock rise, second with the fall
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_ff <= C_IDLE;
            dq_ff <= '0;
            oe_n_ff <= '1;
            mask_ff <= 1'h0;
            rcnt_ff <= 2'h0;
        end
        else
        begin
            case (st_ff)
                C_IDLE:
                    if (accept)
                        st_ff <= C_CMD;
                C_CMD:
                    if (at_rise)
                    begin
                        st_ff <= (op_ff == DMP_CMD_WRITE) ? C_WB0 :
                            ((op_ff == DMP_CMD_READ) ? C_RWAIT : C_IDLE);
                        dq_ff <= wbuf_ff[DW-1:0];
                        oe_n_ff <= (op_ff == DMP_CMD_WRITE) ? ~lanes : '1;
                        mask_ff <= (op_ff == DMP_CMD_WRITE) && mbuf_ff[0];
                        rcnt_ff <= 2'h0;
                    end
                C_WB0:
                    if (at_fall)
                    begin
                        st_ff <= C_WB1;
                        dq_ff <= wbuf_ff[2*DW-1:DW];
                        mask_ff <= mbuf_ff[1];
                    end
                C_WB1:
                    if (at_rise)
                    begin
                        st_ff <= C_IDLE;
                        oe_n_ff <= '1;
                        mask_ff <= 1'h0;
                    end
                default:
                    if (push_ff)
                    begin
                        rcnt_ff <= rcnt_ff + 2'h1;
                        if (rcnt_ff == 2'h1)
                            st_ff <= C_IDLE;
                    end
            endcase
        end
    end
    assign link.clock = clk_pin_ff;
    assign link.clock_n = ~clk_pin_ff;
    assign link.wr_strobe_lo = stb_pin_ff;
    assign link.wr_strobe_lo_n = ~stb_pin_ff;
    assign link.wr_strobe_hi = stb_pin_ff;
    assign link.wr_strobe_hi_n = ~stb_pin_ff;
    assign link.cs_n = cs_n_ff;
    assign link.we_n = op_ff[1];
    assign link.ref_n = op_ff[0];
    assign link.addr_in = addr_ff;
    assign link.bank_sel = bank_ff;
    assign link.write_mask = mask_ff;
    assign link.ctl_dq_o = dq_ff;
    assign link.ctl_dq_oe_n = oe_n_ff;
    assign width_o = width_ff;
    // ==========================================
    // Read capture through three-stage synchronisers
    logic [SW-1:0] s1_ff;
    logic [SW-1:0] s2_ff;
    logic [SW-1:0] s3_ff;
    logic [1:0] lvl_ff;
    logic [1:0] chg;
    logic [DW-1:0] cap_ff;
    logic [DW-1:0] take;
    wire logic vld_s = s3_ff[2];
    for (genvar gi = 0; gi < 2; gi++)
    begin : g_edge
        assign chg[gi] = (s2_ff[gi] == s3_ff[gi]) && (s3_ff[gi] != lvl_ff[gi]);
    end
    // each lane follows its own strobe pair
    for (genvar gl = 0; gl < DW; gl++)
    begin : g_lane
        localparam bit HI36 = (gl >= `DMP_GRP_W);
        localparam bit HI18 = (gl >= `DMP_X18_SPLIT) && (gl < `DMP_GRP_W);
        wire logic use_hi = (width_ff == DMP_X36 && HI36) || (width_ff == DMP_X18 && HI18);
        assign take[gl] = vld_s && (use_hi ? chg[1] : chg[0]);
    end
    // Sample, find edges, keep flagged beats
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= 2'h0;
            cap_ff <= '0;
            push_ff <= 1'h0;
        end
        else
        begin
            s1_ff <= {link.data_bus, link.read_valid, link.rd_strobe_hi, link.rd_strobe_lo};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= lvl_ff ^ chg;
            cap_ff <= (cap_ff & ~take) | (s3_ff[SW-1:3] & take);
            push_ff <= vld_s && chg[0];
        end
    end
    dmp_fifo #(.WIDTH(DW), .DEPTH(`DMP_FIFO_DEPTH)) u_rd_fifo
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_valid_i(push_ff),
        .in_ready_o(fifo_rdy),
        .in_data_i(cap_ff),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o),
        .count_o(fifo_cnt)
    );
endmodule : dmp_ctl_end
`default_nettype wire

// File: hdl/dmp_dev_end.sv
// Memory device end: command sampling, write capture, free-running read strobes
// ==========================================
// Overview of operation
// - Latch address and command on clock rise
// - Config load takes settings from address
// - Bank select picks one of eight banks
// - Command decoded from write, refresh, select
// - Select high ignores new commands
// - Write data captured on both strobe edges
// - x36 lanes split over two strobe pairs
// - Controller drives every write strobe pair
// - Mask high discards that beat
// - Unused mask held low by controller
// - Shared 36-bit two-way data bus
// - Read data driven at double rate
// - Read strobes toggle continuously, complementary
// - Read data launched with strobe transitions
// - x36 read pairs split lanes 0-17/18-35
// - x18 read pairs split lanes 0-8/9-17
// - x9 uses read pair zero only
// - Read-valid marks beats, strobe-aligned
`include "dmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dmp_dev_end
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    dmp_link_if.dev link,
    output logic cmd_take_o,
    output var dmp_pkg::dmp_cmd_t cmd_o,
    output logic [`DMP_BANK_W-1:0] bank_o,
    output logic [`DMP_ADDR_W-1:0] addr_o,
    output var dmp_pkg::dmp_width_t width_o,
    output logic wr_commit_o,
    output logic wr_drop_o
);
    import dmp_pkg::*;
    localparam int DW = `DMP_DQ_W;
    localparam int GW = `DMP_GRP_W;
    localparam int IW = `DMP_BANK_W + `DMP_COL_W;
    localparam int SW = DW + `DMP_ADDR_W + `DMP_BANK_W + 7;
    localparam int AL = 10;
    // ==========================================
    // Pin sampling
    logic [SW-1:0] s1_ff;
    logic [SW-1:0] s2_ff;
    logic [SW-1:0] s3_ff;
    logic [2:0] lvl_ff;
    logic [2:0] chg;
    wire logic [2:0] rise = chg & s3_ff[2:0];
    wire logic [2:0] fall = chg & ~s3_ff[2:0];
    // Edge counts once second and third stage agree
    for (genvar gi = 0; gi < 3; gi++)
    begin : g_edge
        assign chg[gi] = (s2_ff[gi] == s3_ff[gi]) && (s3_ff[gi] != lvl_ff[gi]);
    end
    // Data and control ride the same pipe as their strobes
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= 3'h0;
        end
        else
        begin
            s1_ff <= {link.data_bus, link.addr_in, link.bank_sel, link.ref_n, link.we_n,
                link.cs_n, link.write_mask, link.wr_strobe_hi, link.wr_strobe_lo, link.clock};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= lvl_ff ^ chg;
        end
    end
    // ==========================================
    // Command decode
    wire logic [DW-1:0] dq_s = s3_ff[SW-1:SW-DW];
    wire logic [`DMP_ADDR_W-1:0] addr_s = s3_ff[AL +: `DMP_ADDR_W];
    wire logic [`DMP_BANK_W-1:0] bank_s = s3_ff[7 +: `DMP_BANK_W];
    wire logic mask_s = s3_ff[3];
    // command from write and refresh lines
    wire dmp_cmd_t cmd_s = dmp_cmd_t'({s3_ff[5], s3_ff[6]});
    // take on clock rise; only while selected
    wire logic take = rise[0] && !s3_ff[4];
    // bank and column form the storage index
    wire logic [IW-1:0] idx_s = {bank_s, addr_s[`DMP_COL_W-1:0]};
    wire logic cfg_ok = take && cmd_s == DMP_CMD_CFG && addr_s[1:0] != 2'h3;
    logic cmd_take_ff;
    dmp_cmd_t cmd_ff;
    logic [`DMP_BANK_W-1:0] bank_ff;
    logic [`DMP_ADDR_W-1:0] addr_ff;
    dmp_width_t width_ff;
    // Hold the last taken command for the user side
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cmd_take_ff <= 1'h0;
            cmd_ff <= DMP_CMD_READ;
            bank_ff <= '0;
            addr_ff <= '0;
            width_ff <= dmp_width_t'(`DMP_CFG_WIDTH_RST);
        end
        else
        begin
            cmd_take_ff <= take;
            if (take)
            begin
                cmd_ff <= cmd_s;
                bank_ff <= bank_s;
                addr_ff <= addr_s;
            end
            if (cfg_ok)
                width_ff <= dmp_width_t'(addr_s[`DMP_CFG_WIDTH_LSB +: 2]);
        end
    end
    // ==========================================
    // Write capture
    wire logic x36 = (width_ff == DMP_X36);
    logic wr_arm_ff;
    logic wr_beat_ff;
    logic [2:0] seen_ff;
    logic [IW-1:0] wr_idx_ff;
    logic [DW-1:0] grp_ff;
    logic mask_ff;
    logic [2:0] hit;
    logic [DW-1:0] mem_ff [2**(IW+1)];
    // upper lanes and mask follow pair one only in x36
    for (genvar gk = 0; gk < 3; gk++)
    begin : g_src
        wire logic use_hi = (gk != 0) && x36;
        // rise gives beat zero, fall gives beat one; bit 1 is the low pair
        assign hit[gk] = wr_arm_ff && !seen_ff[gk] &&
            (use_hi ? (wr_beat_ff ? fall[2] : rise[2]) : (wr_beat_ff ? fall[1] : rise[1]));
    end
    wire logic commit = wr_arm_ff && (&(seen_ff | hit));
    wire logic [DW-1:0] wdata = {hit[1] ? dq_s[DW-1:GW] : grp_ff[DW-1:GW],
        hit[0] ? dq_s[GW-1:0] : grp_ff[GW-1:0]};
    wire logic wmask = hit[2] ? mask_s : mask_ff;
    // Gather both lane groups and the mask of one beat
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_arm_ff <= 1'h0;
            wr_beat_ff <= 1'h0;
            seen_ff <= 3'h0;
            wr_idx_ff <= '0;
            grp_ff <= '0;
            mask_ff <= 1'h0;
        end
        else if (take && cmd_s == DMP_CMD_WRITE)
        begin
            wr_arm_ff <= 1'h1;
            wr_beat_ff <= 1'h0;
            seen_ff <= 3'h0;
            wr_idx_ff <= idx_s;
        end
        else
        begin
            grp_ff <= wdata;
            mask_ff <= wmask;
            seen_ff <= commit ? 3'h0 : (seen_ff | hit);
            wr_beat_ff <= wr_beat_ff ^ commit;
            wr_arm_ff <= wr_arm_ff && !(commit && wr_beat_ff);
        end
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (commit && !wmask)
            mem_ff[{wr_idx_ff, wr_beat_ff}] <= wdata;
    end
    // ==========================================
    // Read launch on the free-running strobe
    logic [2:0] rd_cnt_ff;
    logic rd_stb_ff;
    logic rd_pend_ff;
    logic [IW-1:0] rd_idx_ff;
    dmp_rd_st_t rd_st_ff;
    logic [DW-1:0] rd_dq_ff;
    logic [DW-1:0] rd_oe_n_ff;
    logic rd_vld_ff;
    wire logic tick = (rd_cnt_ff == 3'(`DMP_HALF_CYC - 1));
    wire logic start = tick && rd_pend_ff && (rd_st_ff != RD_BEAT0);
    // lane groups by width; x36 drives all
    wire logic [DW-1:0] lanes = (width_ff == DMP_X9) ? `DMP_LANES_X9 :
        ((width_ff == DMP_X18) ? `DMP_LANES_X18 : `DMP_LANES_X36);
    // strobe toggles every half period, reads or not
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_cnt_ff <= 3'h0;
            rd_stb_ff <= 1'h0;
        end
        else
        begin
            rd_cnt_ff <= tick ? 3'h0 : rd_cnt_ff + 3'h1;
            rd_stb_ff <= rd_stb_ff ^ tick;
        end
    end
    // A new read sets pending even as an older one starts
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_pend_ff <= 1'h0;
            rd_idx_ff <= '0;
        end
        else if (take && cmd_s == DMP_CMD_READ)
        begin
            rd_pend_ff <= 1'h1;
            rd_idx_ff <= idx_s;
        end
        else if (start)
            rd_pend_ff <= 1'h0;
    end
    // data and valid change on strobe edges
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_st_ff <= RD_IDLE;
            rd_dq_ff <= '0;
            rd_oe_n_ff <= '1;
            rd_vld_ff <= 1'h0;
        end
        else if (start)
        begin
            rd_st_ff <= RD_BEAT0;
            rd_dq_ff <= mem_ff[{rd_idx_ff, 1'h0}];
            rd_oe_n_ff <= ~lanes;
            rd_vld_ff <= 1'h1;
        end
        else if (tick && rd_st_ff == RD_BEAT0)
        begin
            rd_st_ff <= RD_BEAT1;
            rd_dq_ff <= mem_ff[{rd_idx_ff, 1'h1}];
        end
        else if (tick)
        begin
            rd_st_ff <= RD_IDLE;
            rd_oe_n_ff <= '1;
            rd_vld_ff <= 1'h0;
        end
    end
    // two-way bus as output plus low-active enable
    assign link.dev_dq_o = rd_dq_ff;
    assign link.dev_dq_oe_n = rd_oe_n_ff;
    assign link.rd_strobe_lo = rd_stb_ff;
    assign link.rd_strobe_lo_n = ~rd_stb_ff;
    assign link.rd_strobe_hi = rd_stb_ff;
    assign link.rd_strobe_hi_n = ~rd_stb_ff;
    assign link.read_valid = rd_vld_ff;
    assign cmd_take_o = cmd_take_ff;
    assign cmd_o = cmd_ff;
    assign bank_o = bank_ff;
    assign addr_o = addr_ff;
    assign width_o = width_ff;
    assign wr_commit_o = commit && !wmask;
    assign wr_drop_o = commit && wmask;
endmodule : dmp_dev_end
`default_nettype wire

// File: dv/dmp_link_monitor.sv
// Checker on the memory pin link between both ends
`include "dmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dmp_link_monitor
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic rd_strobe_lo,
    input wire logic rd_strobe_hi,
    input wire logic wr_strobe_lo,
    input wire logic wr_strobe_hi,
    input wire logic write_mask,
    input wire logic read_valid,
    input wire logic [`DMP_DQ_W-1:0] ctl_dq_oe_n,
    input wire logic [`DMP_DQ_W-1:0] dev_dq_oe_n
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    // ==========
    // Strobe, valid and bus relations
    sequence tog_s;
        $changed(rd_strobe_lo);
    endsequence
    sequence burst_s;
        read_valid[*8] ##1 !read_valid;
    endsequence
    strobe_run_a: assert property (tog_s |=> $stable(rd_strobe_lo)[*3] ##1 tog_s)
        else $error("strobe period");
    strobe_pair_a: assert property (rd_strobe_hi == rd_strobe_lo)
        else $error("read pairs apart");
    valid_edge_a: assert property ($changed(read_valid) |-> tog_s)
        else $error("valid off edge");
    dq_edge_a: assert property ($changed(dev_dq_oe_n) |-> tog_s)
        else $error("data off edge");
    valid_len_a: assert property ($rose(read_valid) |-> burst_s)
        else $error("burst length");
    bus_free_a: assert property (!read_valid |-> &dev_dq_oe_n)
        else $error("bus driven idle");
    mask_idle_a: assert property (&ctl_dq_oe_n |-> !write_mask)
        else $error("mask high idle");
    wr_pair_a: assert property (wr_strobe_hi == wr_strobe_lo)
        else $error("write pairs apart");
endmodule : dmp_link_monitor
`default_nettype wire

// File: dv/test_ddr_memory_pin_interface.sv
// Bench joining the controller end and the device end of the pin link
`include "dmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_ddr_memory_pin_interface;
    import dmp_pkg::*;
    typedef struct packed {dmp_cmd_t op; logic [2:0] bank; logic [21:0] addr;
        logic [35:0] d0; logic [35:0] d1; logic [1:0] mask; dmp_width_t ew;} dmp_row_t;
    localparam PA = 36'hA5A5A5A5A, PB = 36'h5A5A5A5A5;
    localparam PC = 36'h123456789, PD = 36'hFEDCBA987;
    logic clk_sys_i = 0, reset_i = 1, cmd_valid_i = 0, rd_ready_i = 1;
    logic cmd_ready_o, rd_valid_o, cmd_take_o, wr_commit_o, wr_drop_o;
    dmp_cmd_t cmd_op_i = DMP_CMD_READ, cmd_o;
    logic [2:0] cmd_bank_i = '0, bank_o;
    logic [21:0] cmd_addr_i = '0, addr_o;
    logic [71:0] wr_data_i = '0;
    logic [1:0] wr_mask_i = '0;
    logic [35:0] rd_data_o;
    dmp_width_t w_ctl, w_dev;
    int errors = 0, compares = 0, commits = 0, drops = 0, takes = 0;
    // Ordinary cases: command, place, beats, mask, width after it
    dmp_row_t rows[12] = '{
        '{DMP_CMD_WRITE, 3'h5, 22'h2AAAA9, PA, PB, 2'h0, DMP_X36},
        '{DMP_CMD_READ, 3'h5, 22'h1, PA, PB, 2'h0, DMP_X36},
        '{DMP_CMD_WRITE, 3'h5, 22'h1, PC, PD, 2'h1, DMP_X36},
        '{DMP_CMD_WRITE, 3'h5, 22'h1, '0, '0, 2'h3, DMP_X36},
        '{DMP_CMD_READ, 3'h5, 22'h1, PA, PD, 2'h0, DMP_X36},
        '{DMP_CMD_CFG, 3'h0, 22'h3, '0, '0, 2'h0, DMP_X36},
        '{DMP_CMD_REFRESH, 3'h7, 22'h1, '0, '0, 2'h0, DMP_X36},
        '{DMP_CMD_CFG, 3'h0, 22'h0, '0, '0, 2'h0, DMP_X9},
        '{DMP_CMD_WRITE, 3'h2, 22'h2, PC, PB, 2'h0, DMP_X9},
        '{DMP_CMD_READ, 3'h2, 22'h2, PC, PB, 2'h0, DMP_X9},
        '{DMP_CMD_CFG, 3'h0, 22'h1, '0, '0, 2'h0, DMP_X18},
        '{DMP_CMD_READ, 3'h5, 22'h1, PA, PD, 2'h0, DMP_X18}
    };
    dmp_link_if link();
    dmp_ctl_end dmp_ctl_end_inst (.*, .width_o(w_ctl));
    dmp_dev_end dmp_dev_end_inst (.*, .width_o(w_dev));
    dmp_link_monitor dmp_link_monitor_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .rd_strobe_lo(link.rd_strobe_lo), .rd_strobe_hi(link.rd_strobe_hi),
        .wr_strobe_lo(link.wr_strobe_lo), .wr_strobe_hi(link.wr_strobe_hi),
        .write_mask(link.write_mask), .read_valid(link.read_valid),
        .ctl_dq_oe_n(link.ctl_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n));
    // System clock
    always #12.5 clk_sys_i = ~clk_sys_i;
    // Count stored and discarded write beats
    always @(posedge clk_sys_i) commits += wr_commit_o;
    always @(posedge clk_sys_i) drops += wr_drop_o;
    // Count commands taken by the device end
    always @(posedge clk_sys_i) takes += cmd_take_o;
    // Compare one result
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Print counts and verdict, then stop
    task automatic finish_test;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Bounded wait for a level high
    task automatic wait_hi(ref logic s);
        int n;
        for (n = 0; n < 100 && s !== 1'b1; n++)
            @(negedge clk_sys_i);
        if (n == 100)
        begin
            errors++;
            finish_test();
        end
    endtask : wait_hi
    // Issue one row and compare what both ends show
    task automatic run_row(input dmp_row_t r);
        logic [35:0] ln;
        ln = r.ew == DMP_X9 ? `DMP_LANES_X9 : (r.ew == DMP_X18 ? `DMP_LANES_X18 : `DMP_LANES_X36);
        {cmd_op_i, cmd_bank_i, cmd_addr_i} = {r.op, r.bank, r.addr};
        {wr_data_i, wr_mask_i, cmd_valid_i} = {r.d1, r.d0, r.mask, 1'b1};
        wait_hi(cmd_ready_o);
        @(posedge clk_sys_i);
        #1 cmd_valid_i = 0;
        {commits, drops, takes} = '0;
        wait_hi(cmd_take_o);
        check(cmd_o, r.op);
        check(bank_o, r.bank);
        check(addr_o, r.addr);
        for (int k = 0; k < 2 && r.op == DMP_CMD_READ; k++)
        begin
            wait_hi(rd_valid_o);
            check(rd_data_o & ln, (k ? r.d1 : r.d0) & ln);
            @(posedge clk_sys_i);
            #1;
        end
        repeat (16) @(posedge clk_sys_i);
        #1;
        check(w_ctl, r.ew);
        check(w_dev, r.ew);
        check(takes, 1);
        check(rd_valid_o, 1'b0);
        if (r.op == DMP_CMD_WRITE)
        begin
            check(drops, $countones(r.mask));
            check(commits, 2 - $countones(r.mask));
        end
    endtask : run_row
    // Main sequence: rows, then a reset in mid-run and recovery
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        #1 reset_i = 0;
        foreach (rows[i])
            run_row(rows[i]);
        reset_i = 1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        check(link.cs_n, 1'b1);
        check(link.read_valid, 1'b0);
        check(w_dev, DMP_X36);
        reset_i = 0;
        run_row(rows[7]);
        finish_test();
    end
endmodule : test_ddr_memory_pin_interface
`default_nettype wire
